//--- wake_cfg_params.svh
`ifndef WAKE_CFG_PARAMS_SVH
`define WAKE_CFG_PARAMS_SVH

// Register indices on the internal 7-bit register port.
`define OFS_PAYLOAD_3_2 7'h39
`define OFS_PAYLOAD_1_0 7'h3a
`define OFS_FD_CONFIG 7'h3b
`define OFS_RX_SELECT 7'h3c

// Field positions.
`define POS_BYTE_HI_MSB 15
`define POS_BYTE_HI_LSB 8
`define POS_BYTE_LO_MSB 7
`define POS_BYTE_LO_LSB 0
`define POS_ERR_CNT_DIS 5
`define POS_FILTER_MSB 3
`define POS_FILTER_LSB 1
`define POS_FD_EN 0
`define POS_RX_SELECT 14

// Reset values.
`define RST_PAYLOAD 16'h0000
`define RST_FD_CONFIG 16'h0000
`define RST_RX_SELECT 1'b0

// Dominant filter times in ns, and their cycle counts rounded up.
`define CLK_PERIOD_NS 40
`define CEIL_CYCLES(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_NS_0 50
`define FILT_NS_1 100
`define FILT_NS_2 150
`define FILT_NS_3 200
`define FILT_NS_4 250
`define FILT_NS_5 300
`define FILT_NS_6 350
`define FILT_NS_7 775
`define FILT_CNT_W 5

`endif

//--- wake_cfg_pkg.sv
package wake_cfg_pkg;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] payload_byte_3;
		logic [7:0] payload_byte_2;
		logic [7:0] payload_byte_1;
		logic [7:0] payload_byte_0;
		logic error_counter_disable;
		logic [2:0] dominant_filter_time;
		logic fd_tolerant_enable;
		logic wake_receiver_select;
		logic [15:0] rdata;
		logic error_counter_run;
		logic receiver_standard;
		logic dlc_match;
		logic dlc_match_valid;
		logic [4:0] filter_cycles;
	} cfg_state_t;

	typedef struct packed {
		logic [4:0] count;
		logic dominant_out;
	} filter_state_t;

endpackage : wake_cfg_pkg

//--- dominant_filter.sv
`timescale 1ns/1ps
`include "wake_cfg_params.svh"

module dominant_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic rx_dominant,
	input wire logic [`FILT_CNT_W-1:0] threshold,
	output logic dominant_out
);

	wake_cfg_pkg::filter_state_t s_q;
	wake_cfg_pkg::filter_state_t s_d;

	// A dominant level passes only after it has held for the threshold
	// count; shorter pulses are treated as FD data-phase noise.
	always_comb begin
		s_d = s_q;
		if (!enable || !rx_dominant) begin
			s_d.count = '0;
			s_d.dominant_out = rx_dominant && !enable;
		end else begin
			if (s_q.count != {`FILT_CNT_W{1'b1}}) begin
				s_d.count = s_q.count + 5'h01;
			end
			s_d.dominant_out = (s_d.count >= threshold);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dominant_out = s_q.dominant_out;

endmodule : dominant_filter

//--- wake_frame_cfg.sv
// What this block does
// RQ1 - Payload byte 3 high, byte 2 low
// RQ2 - Payload byte 1 high, byte 0 low
// RQ3 - FD reserved bits 15:6 and 4 read zero
// RQ4 - Disable stops the counter only when FD enabled
// RQ5 - Filter code selects 50-350 ns or 775 ns
// RQ6 - Bit 0 enables FD tolerant mode
// RQ7 - Silence timeout clears error counter disable
// RQ8 - Software picks normal receiver above 2 Mbit/s
// RQ9 - Receiver select: 0 low power, 1 standard
// RQ10 - Frame matches only with identical DLC
// RQ11 - Reset clears all; restart keeps settings
`timescale 1ns/1ps
`include "wake_cfg_params.svh"

module wake_frame_cfg (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic restart,
	input wire wake_cfg_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	input wire logic selective_wake_active,
	input wire logic silence_timeout,
	input wire logic rx_dominant,
	input wire logic [3:0] cfg_dlc,
	input wire logic [3:0] rx_dlc,
	input wire logic rx_dlc_valid,
	output logic rx_dominant_filtered,
	output logic error_counter_run,
	output logic receiver_standard,
	output logic dlc_match,
	output logic dlc_match_valid,
	output logic [7:0] payload_byte_3,
	output logic [7:0] payload_byte_2,
	output logic [7:0] payload_byte_1,
	output logic [7:0] payload_byte_0,
	output logic fd_tolerant_enable
);

	wake_cfg_pkg::cfg_state_t s_q;
	wake_cfg_pkg::cfg_state_t s_d;
	logic [4:0] filt_cycles;
	logic wr_taken;
	logic wr_payload_3_2;
	logic wr_payload_1_0;
	logic wr_fd_config;
	logic wr_rx_select;
	logic [7:0] wdata_hi;
	logic [7:0] wdata_lo;
	logic wdata_err_cnt_dis;
	logic [2:0] wdata_filter;
	logic wdata_fd_en;
	logic wdata_rx_select;
	logic [15:0] word_payload_3_2;
	logic [15:0] word_payload_1_0;
	logic [15:0] word_fd_config;
	logic [15:0] word_rx_select;

	////////////////////////////////////////////////////////////////////////
	// Filter code to cycle count at the 40 ns clock, rounded up so the
	// filter never passes a pulse shorter than the selected time.
	function automatic logic [4:0] filter_count(input logic [2:0] code);
		logic [4:0] c;
		c = 5'h00;
		case (code)
			3'h0: c = 5'(`CEIL_CYCLES(`FILT_NS_0)); // [RQ5]
			3'h1: c = 5'(`CEIL_CYCLES(`FILT_NS_1));
			3'h2: c = 5'(`CEIL_CYCLES(`FILT_NS_2));
			3'h3: c = 5'(`CEIL_CYCLES(`FILT_NS_3));
			3'h4: c = 5'(`CEIL_CYCLES(`FILT_NS_4));
			3'h5: c = 5'(`CEIL_CYCLES(`FILT_NS_5));
			3'h6: c = 5'(`CEIL_CYCLES(`FILT_NS_6));
			default: c = 5'(`CEIL_CYCLES(`FILT_NS_7));
		endcase
		return c;
	endfunction : filter_count

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		if (soft_reset) begin
			s_d = '0; // [RQ11]
			s_d.filter_cycles = filter_count(3'h0);
		end else begin
			// Restart is a no-op on the stored settings by design. [RQ11]
			if (wr_payload_3_2) begin
				s_d.payload_byte_3 = wdata_hi; // [RQ1]
				s_d.payload_byte_2 = wdata_lo;
			end
			if (wr_payload_1_0) begin
				s_d.payload_byte_1 = wdata_hi; // [RQ2]
				s_d.payload_byte_0 = wdata_lo;
			end
			if (wr_fd_config) begin
				s_d.error_counter_disable = wdata_err_cnt_dis;
				s_d.dominant_filter_time = wdata_filter; // [RQ5]
				s_d.fd_tolerant_enable = wdata_fd_en; // [RQ6]
			end
			if (wr_rx_select) begin
				s_d.wake_receiver_select = wdata_rx_select; // [RQ9]
			end
			// Hardware clear beats a same-cycle software write of a one.
			if (silence_timeout) begin
				s_d.error_counter_disable = 1'b0; // [RQ7]
			end
			s_d.filter_cycles = filter_count(s_d.dominant_filter_time);
		end

		// The derived outputs follow the stored state one cycle late, and a
		// soft reset holds them low together with the registers. [RQ11]
		if (!soft_reset) begin
			// The disable only takes effect while FD tolerant mode is on.
			s_d.error_counter_run = selective_wake_active &&
				!(s_q.error_counter_disable && s_q.fd_tolerant_enable); // [RQ4]
			s_d.receiver_standard = s_q.wake_receiver_select; // [RQ9]

			s_d.dlc_match_valid = rx_dlc_valid;
			if (rx_dlc_valid) begin
				s_d.dlc_match = (rx_dlc == cfg_dlc); // [RQ10]
			end

			// Read data lags the address by one cycle; unmapped reads give zero.
			s_d.rdata = 16'h0000;
			if (reg_req.addr == `OFS_PAYLOAD_3_2) begin
				s_d.rdata = word_payload_3_2; // [RQ1]
			end else if (reg_req.addr == `OFS_PAYLOAD_1_0) begin
				s_d.rdata = word_payload_1_0; // [RQ2]
			end else if (reg_req.addr == `OFS_FD_CONFIG) begin
				s_d.rdata = word_fd_config; // [RQ3]
			end else if (reg_req.addr == `OFS_RX_SELECT) begin
				s_d.rdata = word_rx_select; // [RQ9]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0; // [RQ11]
			s_q.filter_cycles <= 5'(`CEIL_CYCLES(`FILT_NS_0));
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writes are decoded into one strobe per register. A write during restart
	// or soft reset is dropped here, so the stored wake pattern survives a
	// restart untouched. [RQ11]
	assign wr_taken = reg_req.wr && !restart && !soft_reset;

	always_comb begin
		wr_payload_3_2 = 1'b0;
		wr_payload_1_0 = 1'b0;
		wr_fd_config = 1'b0;
		wr_rx_select = 1'b0;
		if (reg_req.addr == `OFS_PAYLOAD_3_2) begin
			wr_payload_3_2 = wr_taken;
		end else if (reg_req.addr == `OFS_PAYLOAD_1_0) begin
			wr_payload_1_0 = wr_taken;
		end else if (reg_req.addr == `OFS_FD_CONFIG) begin
			wr_fd_config = wr_taken;
		end else if (reg_req.addr == `OFS_RX_SELECT) begin
			wr_rx_select = wr_taken;
		end
	end

	// Field views of the write data; reserved positions are never picked up.
	assign wdata_hi = reg_req.wdata[`POS_BYTE_HI_MSB:`POS_BYTE_HI_LSB];
	assign wdata_lo = reg_req.wdata[`POS_BYTE_LO_MSB:`POS_BYTE_LO_LSB];
	assign wdata_err_cnt_dis = reg_req.wdata[`POS_ERR_CNT_DIS];
	assign wdata_filter = reg_req.wdata[`POS_FILTER_MSB:`POS_FILTER_LSB];
	assign wdata_fd_en = reg_req.wdata[`POS_FD_EN];
	assign wdata_rx_select = reg_req.wdata[`POS_RX_SELECT];

	////////////////////////////////////////////////////////////////////////
	// Read-back words. The FD word is built bit by bit so that every
	// reserved position is tied low and can never show a stray value.
	assign word_payload_3_2 = {s_q.payload_byte_3, s_q.payload_byte_2}; // [RQ1]
	assign word_payload_1_0 = {s_q.payload_byte_1, s_q.payload_byte_0}; // [RQ2]

	for (genvar i = 0; i < 16; i++) begin : g_fd_bit
		if (i == `POS_ERR_CNT_DIS) begin : g_dis
			assign word_fd_config[i] = s_q.error_counter_disable; // [RQ4]
		end else if (i >= `POS_FILTER_LSB && i <= `POS_FILTER_MSB) begin : g_filt
			assign word_fd_config[i] = s_q.dominant_filter_time[i - `POS_FILTER_LSB];
		end else if (i == `POS_FD_EN) begin : g_en
			assign word_fd_config[i] = s_q.fd_tolerant_enable; // [RQ6]
		end else begin : g_rsv
			assign word_fd_config[i] = 1'b0; // [RQ3]
		end
	end

	// Only the receiver-select bit is kept in its word; the rest reads low.
	always_comb begin
		word_rx_select = 16'h0000;
		word_rx_select[`POS_RX_SELECT] = s_q.wake_receiver_select; // [RQ9]
	end

	////////////////////////////////////////////////////////////////////////
	assign filt_cycles = s_q.filter_cycles;

	// The filter sees the registered enable, so a mode change written in one
	// cycle governs the dominant samples from the following cycle on.
	dominant_filter u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.enable(s_q.fd_tolerant_enable),
		.rx_dominant(rx_dominant),
		.threshold(filt_cycles),
		.dominant_out(rx_dominant_filtered)
	);

	assign reg_rdata = s_q.rdata;
	assign error_counter_run = s_q.error_counter_run;
	assign receiver_standard = s_q.receiver_standard;
	assign dlc_match = s_q.dlc_match;
	assign dlc_match_valid = s_q.dlc_match_valid;
	assign payload_byte_3 = s_q.payload_byte_3;
	assign payload_byte_2 = s_q.payload_byte_2;
	assign payload_byte_1 = s_q.payload_byte_1;
	assign payload_byte_0 = s_q.payload_byte_0;
	assign fd_tolerant_enable = s_q.fd_tolerant_enable;

endmodule : wake_frame_cfg

//--- wake_cfg_sva.sv
`timescale 1ns/1ps
`include "wake_cfg_params.svh"
module wake_cfg_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic restart,
	input wire wake_cfg_pkg::reg_req_t reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic selective_wake_active,
	input wire logic silence_timeout,
	input wire logic rx_dominant,
	input wire logic [3:0] cfg_dlc,
	input wire logic [3:0] rx_dlc,
	input wire logic rx_dlc_valid,
	input wire logic rx_dominant_filtered,
	input wire logic error_counter_run,
	input wire logic receiver_standard,
	input wire logic dlc_match,
	input wire logic dlc_match_valid,
	input wire logic [7:0] payload_byte_3,
	input wire logic [7:0] payload_byte_2,
	input wire logic [7:0] payload_byte_1,
	input wire logic [7:0] payload_byte_0,
	input wire logic fd_tolerant_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ok;
	assign ok = !soft_reset && !restart;
	sequence s_wr(a);
		reg_req.wr && ok && reg_req.addr == a;
	endsequence
	// The disable bit is hidden, so its clearing is judged through the counter run output.
	sequence s_silence;
		silence_timeout && !soft_reset ##1 fd_tolerant_enable && selective_wake_active && !soft_reset;
	endsequence
	AST_PAY_HI: assert property (
		s_wr(`OFS_PAYLOAD_3_2) |=> {payload_byte_3, payload_byte_2} == $past(reg_req.wdata))
		else $error("bytes 3 2 wrong");
	AST_PAY_LO: assert property (
		s_wr(`OFS_PAYLOAD_1_0) |=> {payload_byte_1, payload_byte_0} == $past(reg_req.wdata))
		else $error("bytes 1 0 wrong");
	AST_FD_RSV: assert property (
		$past(reg_req.addr) == `OFS_FD_CONFIG |-> reg_rdata[15:6] == 10'h000 && !reg_rdata[4])
		else $error("reserved bit set");
	AST_RUN: assert property (
		!fd_tolerant_enable && !soft_reset |=> error_counter_run == $past(selective_wake_active))
		else $error("counter run wrong");
	AST_FILT_OFF: assert property (
		!fd_tolerant_enable && !soft_reset |=> rx_dominant_filtered == $past(rx_dominant))
		else $error("filter not bypassed");
	AST_FILT_CLR: assert property (
		!rx_dominant && !soft_reset |=> !rx_dominant_filtered)
		else $error("recessive not seen");
	AST_SILENCE: assert property (s_silence |=> error_counter_run)
		else $error("disable not cleared");
	AST_RX_SEL: assert property (
		s_wr(`OFS_RX_SELECT) ##1 !soft_reset |=> receiver_standard == $past(reg_req.wdata[14], 2))
		else $error("receiver select wrong");
	AST_DLC: assert property (
		rx_dlc_valid && !soft_reset |=> dlc_match_valid && dlc_match == ($past(rx_dlc) == $past(cfg_dlc)))
		else $error("dlc match wrong");
	AST_RESTART: assert property (
		restart && !soft_reset |=> $stable({payload_byte_1, payload_byte_0, fd_tolerant_enable}))
		else $error("restart changed state");
endmodule : wake_cfg_sva
bind wake_frame_cfg wake_cfg_sva chk_u (.*);

//--- can_node.sv
`timescale 1ns/1ps
module can_node (
	input wire logic clk,
	output logic rx_dominant,
	output logic [3:0] rx_dlc,
	output logic rx_dlc_valid
);
	initial begin
		rx_dominant = 1'b0;
		rx_dlc = 4'h0;
		rx_dlc_valid = 1'b0;
	end
	task automatic dom(input int len);
		rx_dominant = 1'b1;
		repeat (len) @(negedge clk);
		rx_dominant = 1'b0;
	endtask : dom
	// Outside its strobe the code is inverted so a stale value cannot pass.
	task automatic frame(input logic [3:0] dlc);
		rx_dlc = dlc;
		rx_dlc_valid = 1'b1;
		@(negedge clk);
		rx_dlc_valid = 1'b0;
		rx_dlc = ~dlc;
	endtask : frame
endmodule : can_node

//--- tb_top.sv
`timescale 1ns/1ps
`include "wake_cfg_params.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic restart = 1'b0;
	logic sw_act = 1'b0;
	logic silence = 1'b0;
	logic [3:0] cfg_dlc = 4'h5;
	wake_cfg_pkg::reg_req_t rq = '0;
	logic [15:0] rdata;
	logic rx_dom, filt, run, std, dm, dmv, dv, fd_en;
	logic [3:0] rx_dlc;
	logic [7:0] b3, b2, b1, b0;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	wake_frame_cfg dut_u (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .restart(restart),
		.reg_req(rq), .reg_rdata(rdata), .selective_wake_active(sw_act),
		.silence_timeout(silence), .rx_dominant(rx_dom), .cfg_dlc(cfg_dlc), .rx_dlc(rx_dlc),
		.rx_dlc_valid(dv), .rx_dominant_filtered(filt), .error_counter_run(run),
		.receiver_standard(std), .dlc_match(dm), .dlc_match_valid(dmv), .payload_byte_3(b3),
		.payload_byte_2(b2), .payload_byte_1(b1), .payload_byte_0(b0), .fd_tolerant_enable(fd_en));
	can_node node_u (.clk(clk), .rx_dominant(rx_dom), .rx_dlc(rx_dlc), .rx_dlc_valid(dv));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// The strobe stays up so back-to-back writes never touch it twice in one step.
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		rq = '{1'b1, a, d};
		@(negedge clk);
	endtask : wr
	task automatic rd(input string name, input logic [6:0] a, input logic [15:0] exp);
		rq = '{1'b0, a, 16'h0000};
		@(negedge clk);
		chk(name, exp, rdata);
	endtask : rd
	task automatic t_regs;
		wr(`OFS_PAYLOAD_3_2, 16'ha55a);
		wr(`OFS_PAYLOAD_1_0, 16'h1234);
		wr(`OFS_FD_CONFIG, 16'hffff);
		wr(7'h10, 16'hffff);
		rd("pay32", `OFS_PAYLOAD_3_2, 16'ha55a);
		rd("pay10", `OFS_PAYLOAD_1_0, 16'h1234);
		rd("fdcfg", `OFS_FD_CONFIG, 16'h002f);
		rd("unmapped", 7'h10, 16'h0000);
		chk("bytes32", 16'ha55a, {b3, b2});
		chk("bytes10", 16'h1234, {b1, b0});
		chk("fd_en", 16'h0001, {15'h0, fd_en});
	endtask : t_regs
	task automatic t_reset;
		restart = 1'b1;
		wr(`OFS_PAYLOAD_1_0, 16'hbeef);
		rd("restart", `OFS_PAYLOAD_1_0, 16'h1234);
		restart = 1'b0;
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
		rd("soft", `OFS_PAYLOAD_3_2, 16'h0000);
	endtask : t_reset
	task automatic t_err;
		sw_act = 1'b1;
		wr(`OFS_FD_CONFIG, 16'h0021);
		rd("fdcfg", `OFS_FD_CONFIG, 16'h0021);
		chk("run_off", 16'h0000, {15'h0, run});
		silence = 1'b1;
		@(negedge clk);
		silence = 1'b0;
		rd("dis_clr", `OFS_FD_CONFIG, 16'h0001);
		chk("run_on", 16'h0001, {15'h0, run});
	endtask : t_err
	task automatic t_sel;
		wr(`OFS_RX_SELECT, 16'h4000);
		rd("rxsel", `OFS_RX_SELECT, 16'h4000);
		chk("std", 16'h0001, {15'h0, std});
		wr(`OFS_RX_SELECT, 16'h0000);
		rd("rxsel0", `OFS_RX_SELECT, 16'h0000);
	endtask : t_sel
	task automatic t_filt;
		int n;
		for (int c = 0; c < 8; c++) begin
			n = ((c < 7 ? 50 * (c + 1) : 775) + 39) / 40;
			wr(`OFS_FD_CONFIG, {12'h000, c[2:0], 1'b1});
			rd("fcfg", `OFS_FD_CONFIG, {12'h000, c[2:0], 1'b1});
			node_u.dom(n - 1);
			chk("short", 16'h0000, {15'h0, filt});
			@(negedge clk);
			node_u.dom(n + 1);
			chk("long", 16'h0001, {15'h0, filt});
			@(negedge clk);
		end
		wr(`OFS_FD_CONFIG, 16'h0000);
		rd("fd_off", `OFS_FD_CONFIG, 16'h0000);
		node_u.dom(1);
		chk("bypass", 16'h0001, {15'h0, filt});
	endtask : t_filt
	task automatic t_dlc;
		node_u.frame(4'h5);
		chk("dlc_eq", 16'h0003, {14'h0, dmv, dm});
		@(negedge clk);
		node_u.frame(4'hd);
		chk("dlc_ne", 16'h0002, {14'h0, dmv, dm});
	endtask : t_dlc
	task automatic test_done;
		$display("Compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_regs();
		t_reset();
		t_err();
		t_sel();
		t_filt();
		t_dlc();
		test_done();
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			test_done();
		end
	end
endmodule : tb_top
